// file: core/pwc_pkg.sv
package pwc_pkg;
  localparam int NUM_UNITS = 3;
  localparam int N_CMP = 4;
  localparam int CNT_W = 12;
  localparam int CMP_W = 16;
  localparam int NPIN = 8;
  localparam int NVEC = 6;
  // register map: one 16-byte window per unit, unit number in addr[7:4]
  localparam logic [3:0] OFF_SOC = 4'h0;
  localparam logic [3:0] OFF_CNF = 4'h1;
  localparam logic [3:0] OFF_CTL = 4'h2;
  localparam logic [3:0] OFF_IEN = 4'h3;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_CNT_LO = 4'h5;
  localparam logic [3:0] OFF_CNT_HI = 4'h6;
  localparam logic [3:0] OFF_CMP_BASE = 4'h8;
  // sync_and_output_config fields
  localparam int SOC_FOURTH_SEL = 7;
  localparam int SOC_THIRD_SEL = 6;
  localparam int SOC_SYNC_HI = 5;
  localparam int SOC_SYNC_LO = 4;
  localparam int SOC_FOURTH_EN = 3;
  localparam int SOC_OUT1_EN = 2;
  localparam int SOC_THIRD_EN = 1;
  localparam int SOC_OUT0_EN = 0;
  // instance_config / instance_control / interrupt enable fields
  localparam int CNF_CLK_SEL = 1;
  localparam int CNF_MODE_HI = 4;
  localparam int CNF_MODE_LO = 3;
  localparam int CTL_PRE_HI = 7;
  localparam int CTL_PRE_LO = 6;
  localparam int IEN_EC = 0;
  localparam int IEN_CAPT = 1;
  localparam int CMP_VAL_HI = 11;
  localparam int FINE_HI = 15;
  localparam int FINE_LO = 12;
  localparam int CMP_SA = 0;
  localparam int CMP_RA = 1;
  localparam int CMP_SB = 2;
  localparam int CMP_RB = 3;
  localparam int PIN_THIRD = 6;
  localparam int PIN_FOURTH = 7;
  // prescaler codes and terminal counts (divide by 1, 4, 32, 256)
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_DIV32 = 2'h2;
  localparam logic [1:0] PRE_DIV256 = 2'h3;
  localparam logic [7:0] LIM_DIV1 = 8'h00;
  localparam logic [7:0] LIM_DIV4 = 8'h03;
  localparam logic [7:0] LIM_DIV32 = 8'h1f;
  localparam logic [7:0] LIM_DIV256 = 8'hff;
  localparam logic [1:0] MODE_CENTRED = 2'h3;
  localparam logic [1:0] SYNC_LEAD0 = 2'h0;
  localparam logic [1:0] SYNC_TRAIL0 = 2'h1;
  localparam logic [1:0] SYNC_LEAD1 = 2'h2;
  localparam logic [1:0] SYNC_TRAIL1 = 2'h3;
  localparam logic [15:0] VEC_ADDR_FIRST = 16'h0001;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} pwc_dir_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pwc_req_s;

  typedef struct packed {
    logic [7:0] soc;
    logic [7:0] cnf;
    logic [7:0] ctl;
    logic [7:0] ien;
    logic [N_CMP-1:0][CMP_W-1:0] cmp;
    logic [7:0] pre;
    logic [CNT_W-1:0] cnt;
    pwc_dir_e dir;
    logic [1:0] wave;
  } pwc_unit_s;

  typedef struct packed {
    pwc_unit_s [NUM_UNITS-1:0] unit;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] oe;
    logic [NVEC-1:0] irq;
    logic [NUM_UNITS-1:0] sync;
  } pwc_state_s;
endpackage : pwc_pkg

// file: core/pwc_cfg.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module pwc_cfg
  import pwc_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic PLL_TICK_IN,
  input wire logic [NUM_UNITS-1:0] RETRIG_A_IN,
  input wire logic [NUM_UNITS-1:0] RETRIG_B_IN,
  input wire logic [NUM_UNITS-1:0] CAPT_EVT_IN,
  input wire logic [NPIN-1:0] PORT_DATA_IN,
  input wire logic [NPIN-1:0] PORT_OE_IN,
  output logic [NPIN-1:0] PIN_OUT,
  output logic [NPIN-1:0] PIN_OE_OUT,
  output logic [NVEC-1:0] IRQ_OUT,
  output logic [NUM_UNITS-1:0] SYNC_OUT
);

  // reset image of one unit and of the whole block
  // compare values start at zero: an unprogrammed unit matches on every step,
  // so keep its interrupt enables clear until the compare registers are loaded
  localparam pwc_unit_s UNIT_RST = '{
    soc: REG_RST,
    cnf: REG_RST,
    ctl: REG_RST,
    ien: REG_RST,
    cmp: {N_CMP{CMP_RST}},
    pre: REG_RST,
    cnt: CNT_ZERO,
    dir: DIR_UP,
    wave: 2'h0
  };
  localparam pwc_state_s ST_RST = '{
    unit: {NUM_UNITS{UNIT_RST}},
    temp: REG_RST,
    rdata: REG_RST,
    pin: '0,
    oe: '0,
    irq: '0,
    sync: '0
  };

  // st_r is the only storage; st_nxt is its combinational copy
  pwc_state_s st_r;
  pwc_state_s st_nxt;
  pwc_req_s req;

  // terminal count of the prescaler for a code
  // the count runs from zero to the limit, so the division is the limit plus one
  function automatic logic [7:0] pre_limit(input logic [1:0] code);
    logic [7:0] lim;
    lim = LIM_DIV1;
    unique case (code)
      PRE_DIV1: lim = LIM_DIV1;
      PRE_DIV4: lim = LIM_DIV4;
      PRE_DIV32: lim = LIM_DIV32;
      PRE_DIV256: lim = LIM_DIV256;
    endcase
    return lim;
  endfunction : pre_limit

  // vector slot: unit2 capture first, unit0 end-of-cycle last
  // highest unit sits at the lowest vector address
  function automatic int vec_idx(input int u, input logic is_ec);
    return (NUM_UNITS - 1 - u) * 2 + int'(is_ec);
  endfunction : vec_idx

  // unit number of an address, all-ones when unmapped
  // units above the last one are holes in the map: reads give zero, writes vanish
  function automatic int unit_of(input logic [7:0] a);
    int n;
    n = int'(a[7:4]);
    if (n >= NUM_UNITS) begin
      n = -1;
    end
    return n;
  endfunction : unit_of

  // true for the high byte of a compare register
  function automatic logic is_cmp_hi(input logic [7:0] a);
    return (unit_of(a) >= 0) && (a[3:0] >= OFF_CMP_BASE) && a[0];
  endfunction : is_cmp_hi

  // converter sync choice from mode, code and the cycle's edge events
  function automatic logic sync_pick(
    input logic [1:0] mode,
    input logic [1:0] code,
    input logic [N_CMP-1:0] hit,
    input pwc_dir_e dir,
    input logic ret_a,
    input logic ret_b
  );
    logic s;
    s = 1'b0;
    if (mode == MODE_CENTRED) begin
      unique case (code)
        SYNC_LEAD0: s = hit[CMP_RA] && (dir == DIR_DOWN);
        SYNC_TRAIL0: s = hit[CMP_RA] && (dir == DIR_UP);
        default: s = 1'b0;
      endcase
    end else begin
      unique case (code)
        SYNC_LEAD0: s = hit[CMP_SA];
        SYNC_TRAIL0: s = hit[CMP_RA] || ret_a;
        SYNC_LEAD1: s = hit[CMP_SB];
        SYNC_TRAIL1: s = hit[CMP_RB] || ret_b;
      endcase
    end
    return s;
  endfunction : sync_pick

  // trailing-edge sync from a retrigger that arrives between counter steps;
  // centred mode has no retrigger source for the converter
  function automatic logic retrig_sync(
    input logic [1:0] mode,
    input logic [1:0] code,
    input logic ret_a,
    input logic ret_b
  );
    logic s;
    s = 1'b0;
    if (mode != MODE_CENTRED) begin
      s = (code == SYNC_TRAIL0) && ret_a || (code == SYNC_TRAIL1) && ret_b;
    end
    return s;
  endfunction : retrig_sync

  // extra pin of the last unit: enabled pin follows the chosen generator, else the port
  function automatic logic extra_pin(
    input logic en,
    input logic sel_b,
    input logic wa,
    input logic wb,
    input logic port
  );
    return en ? (sel_b ? wb : wa) : port;
  endfunction : extra_pin

  // bus signals travel together from here on
  assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // counter engine, compare matches, routing and register access
  always_comb begin
    pwc_unit_s un;
    logic tick;
    logic step;
    logic [7:0] lim;
    logic [N_CMP-1:0] hit;
    logic [CNT_W-1:0] top;
    logic [3:0] loc;
    logic wa;
    logic wb;
    un = UNIT_RST;
    tick = 1'b0;
    step = 1'b0;
    lim = LIM_DIV1;
    hit = '0;
    top = CNT_ZERO;
    loc = req.addr[3:0];
    wa = 1'b0;
    wb = 1'b0;
    st_nxt = st_r;
    st_nxt.irq = '0;
    st_nxt.sync = '0;
    if (req.rd) begin
      st_nxt.rdata = REG_RST; // unmapped reads answer zero
    end
    // one holding byte for every compare register of every unit
    // hazard: a low write without its high write commits whatever byte another
    // register left behind; the bus master must keep the high-then-low order
    if (req.wr && is_cmp_hi(req.addr)) begin
      st_nxt.temp = req.wdata;
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      un = st_r.unit[u];
      // counter clock: I/O clock every cycle or the PLL tick
      // the prescaler is not cleared on a code change: a count already past the new
      // limit steps at once, so the first period after a change may be short
      tick = un.cnf[CNF_CLK_SEL] ? PLL_TICK_IN : 1'b1;
      lim = pre_limit(un.ctl[CTL_PRE_HI:CTL_PRE_LO]);
      step = tick && (un.pre >= lim);
      if (tick) begin
        un.pre = (un.pre >= lim) ? REG_RST : un.pre + BYTE_ONE;
      end
      // matches look at the 12-bit value only, fine field excluded
      for (int k = 0; k < N_CMP; k++) begin
        hit[k] = step && (un.cnt == un.cmp[k][CMP_VAL_HI:0]);
      end
      top = un.cmp[CMP_RB][CMP_VAL_HI:0];
      st_nxt.sync[u] = step && sync_pick(un.cnf[CNF_MODE_HI:CNF_MODE_LO],
        un.soc[SOC_SYNC_HI:SOC_SYNC_LO], hit, un.dir, RETRIG_A_IN[u], RETRIG_B_IN[u]) ||
        !step && retrig_sync(un.cnf[CNF_MODE_HI:CNF_MODE_LO], un.soc[SOC_SYNC_HI:SOC_SYNC_LO],
        RETRIG_A_IN[u], RETRIG_B_IN[u]);
      // centred counts up and down between zero and RB, ramps wrap at RB
      // a count above a freshly lowered RB wraps or turns at once rather than
      // running round the whole 12-bit range
      if (step) begin
        if (un.cnf[CNF_MODE_HI:CNF_MODE_LO] == MODE_CENTRED) begin
          unique case (un.dir)
            DIR_UP: begin
              if (un.cnt >= top) begin
                un.dir = DIR_DOWN;
                un.cnt = (un.cnt == CNT_ZERO) ? CNT_ZERO : un.cnt - CNT_ONE;
              end else begin
                un.cnt = un.cnt + CNT_ONE;
              end
            end
            DIR_DOWN: begin
              if (un.cnt == CNT_ZERO) begin
                un.dir = DIR_UP;
                un.cnt = (top == CNT_ZERO) ? CNT_ZERO : CNT_ONE;
              end else begin
                un.cnt = un.cnt - CNT_ONE;
              end
            end
            default: un.dir = DIR_UP;
          endcase
        end else begin
          un.dir = DIR_UP;
          un.cnt = (un.cnt >= top) ? CNT_ZERO : un.cnt + CNT_ONE;
        end
      end
      // generators: set on S match, cleared by R match or retrigger, clear wins
      // clear wins so a retrigger is never masked by a set match in the same step
      if (hit[CMP_SA]) begin
        un.wave[0] = 1'b1;
      end
      if (hit[CMP_RA] || RETRIG_A_IN[u]) begin
        un.wave[0] = 1'b0;
      end
      if (hit[CMP_SB]) begin
        un.wave[1] = 1'b1;
      end
      if (hit[CMP_RB] || RETRIG_B_IN[u]) begin
        un.wave[1] = 1'b0;
      end
      // interrupt requests, one-cycle pulses on their own vector lines
      // nothing is latched here: whoever takes the pulses keeps the pending flags
      st_nxt.irq[vec_idx(u, 1'b1)] = un.ien[IEN_EC] && hit[CMP_RB];
      st_nxt.irq[vec_idx(u, 1'b0)] = un.ien[IEN_CAPT] &&
        (CAPT_EVT_IN[u] || RETRIG_A_IN[u] || RETRIG_B_IN[u]);
      // register writes land after the engine so software has the last word
      // the pins below see a new output config in the same edge as the write, while the
      // sync choice of that same cycle still uses the old one
      if (req.wr && unit_of(req.addr) == u) begin
        if (loc >= OFF_CMP_BASE) begin
          if (!loc[0]) begin
            // low byte commits the buffered high byte with it in one edge
            un.cmp[loc[2:1]] = {st_r.temp, req.wdata};
          end
        end else begin
          unique case (loc)
            OFF_SOC: un.soc = req.wdata;
            OFF_CNF: un.cnf = req.wdata;
            OFF_CTL: un.ctl = req.wdata;
            OFF_IEN: un.ien = req.wdata;
            default: un.ien = un.ien; // status and counter are read-only
          endcase
        end
      end
      // read mux
      // reads return the state before this edge, so a read beside a write of the
      // same register answers the old value
      if (req.rd && unit_of(req.addr) == u) begin
        if (loc >= OFF_CMP_BASE) begin
          st_nxt.rdata = loc[0] ? st_r.unit[u].cmp[loc[2:1]][15:8] : st_r.unit[u].cmp[loc[2:1]][7:0];
        end else begin
          unique case (loc)
            OFF_SOC: st_nxt.rdata = st_r.unit[u].soc;
            OFF_CNF: st_nxt.rdata = st_r.unit[u].cnf;
            OFF_CTL: st_nxt.rdata = st_r.unit[u].ctl;
            OFF_IEN: st_nxt.rdata = st_r.unit[u].ien;
            OFF_STAT: st_nxt.rdata = {5'h00, st_r.unit[u].dir == DIR_DOWN, st_r.unit[u].wave};
            OFF_CNT_LO: st_nxt.rdata = st_r.unit[u].cnt[7:0];
            OFF_CNT_HI: st_nxt.rdata = {4'h0, st_r.unit[u].cnt[CNT_W-1:8]};
            default: st_nxt.rdata = REG_RST;
          endcase
        end
      end
      // pins follow the new waveform or fall back to the port
      // a disabled pin keeps the port's own value and enable untouched
      wa = un.wave[0];
      wb = un.wave[1];
      st_nxt.pin[u * 2] = un.soc[SOC_OUT0_EN] ? wa : PORT_DATA_IN[u * 2];
      st_nxt.oe[u * 2] = un.soc[SOC_OUT0_EN] || PORT_OE_IN[u * 2];
      st_nxt.pin[u * 2 + 1] = un.soc[SOC_OUT1_EN] ? wb : PORT_DATA_IN[u * 2 + 1];
      st_nxt.oe[u * 2 + 1] = un.soc[SOC_OUT1_EN] || PORT_OE_IN[u * 2 + 1];
      // only the last unit owns the two extra pins and their selectors
      if (u == NUM_UNITS - 1) begin
        st_nxt.pin[PIN_THIRD] = extra_pin(un.soc[SOC_THIRD_EN], un.soc[SOC_THIRD_SEL], wa, wb,
          PORT_DATA_IN[PIN_THIRD]);
        st_nxt.oe[PIN_THIRD] = un.soc[SOC_THIRD_EN] || PORT_OE_IN[PIN_THIRD];
        st_nxt.pin[PIN_FOURTH] = extra_pin(un.soc[SOC_FOURTH_EN], !un.soc[SOC_FOURTH_SEL], wa, wb,
          PORT_DATA_IN[PIN_FOURTH]);
        st_nxt.oe[PIN_FOURTH] = un.soc[SOC_FOURTH_EN] || PORT_OE_IN[PIN_FOURTH];
      end
      st_nxt.unit[u] = un;
    end
  end

  // whole state in one register; clock enable low holds every bit
  // a frozen block also stretches any pending one-cycle pulse for as long as
  // the enable stays low
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_r <= ST_RST;
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  // every output is a flip-flop of the state
  // no output path is combinational, so the pads never see a bus glitch
  assign RDATA_OUT = st_r.rdata;
  assign PIN_OUT = st_r.pin;
  assign PIN_OE_OUT = st_r.oe;
  assign IRQ_OUT = st_r.irq;
  assign SYNC_OUT = st_r.sync;

endmodule : pwc_cfg

// file: verif/pwc_stage.sv
`timescale 1ns/1ps
// far side: switches on the pads and the converter sample-and-hold trigger
module pwc_stage
  import pwc_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] oe_in,
  input wire logic [NUM_UNITS-1:0] sync_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NUM_UNITS-1:0][15:0] hits_out
);
  // an undriven pad floats up to the pull-up instead of keeping its last level
  assign pad_out = (pin_in & oe_in) | ~oe_in;
  // converter counts every sync pulse per unit
  initial hits_out = '0;
  always @(posedge clk_in) begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (sync_in[u] === 1'b1) begin
        hits_out[u] <= hits_out[u] + 16'h0001;
      end
    end
  end
endmodule : pwc_stage

// file: verif/pwc_cfg_props.sv
`timescale 1ns/1ps
// port-level checks; config bytes are shadowed from the bus, no hierarchy peeking
module pwc_cfg_props
  import pwc_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic [NUM_UNITS-1:0] CAPT_EVT_IN,
  input wire logic [NPIN-1:0] PORT_OE_IN,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PIN_OE_OUT,
  input wire logic [NVEC-1:0] IRQ_OUT,
  input wire logic [NUM_UNITS-1:0] SYNC_OUT
);
  logic ok_r;
  logic [7:0] soc0_r, soc2_r, ien0_r, cnf0_r;
  // shadow registers; ok_r masks the first edge after reset
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ok_r <= 1'b0;
      {soc0_r, soc2_r, ien0_r, cnf0_r} <= '0;
    end else begin
      ok_r <= CE_IN;
      if (CE_IN && WR_IN && ADDR_IN == 8'h00) soc0_r <= WDATA_IN;
      if (CE_IN && WR_IN && ADDR_IN == 8'h20) soc2_r <= WDATA_IN;
      if (CE_IN && WR_IN && ADDR_IN == 8'h03) ien0_r <= WDATA_IN;
      if (CE_IN && WR_IN && ADDR_IN == 8'h01) cnf0_r <= WDATA_IN;
    end
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence s_capt;
    CE_IN && CAPT_EVT_IN[0] && ien0_r[IEN_CAPT];
  endsequence
  sequence s_ec_off;
    ok_r && !$past(ien0_r[IEN_EC]);
  endsequence
  // pins take a config write in the same edge, so the shadows are read without delay
  property p_oe0;
    ok_r |-> PIN_OE_OUT[0] == (soc0_r[0] || $past(PORT_OE_IN[0]));
  endproperty
  property p_oe1;
    ok_r |-> PIN_OE_OUT[1] == (soc0_r[2] || $past(PORT_OE_IN[1]));
  endproperty
  property p_oe6;
    ok_r |-> PIN_OE_OUT[6] == (soc2_r[1] || $past(PORT_OE_IN[6]));
  endproperty
  property p_oe7;
    ok_r |-> PIN_OE_OUT[7] == (soc2_r[3] || $past(PORT_OE_IN[7]));
  endproperty
  property p_route3;
    ok_r && soc2_r[1] && soc2_r[0] && soc2_r[2] |-> PIN_OUT[6] == (soc2_r[6] ? PIN_OUT[5] : PIN_OUT[4]);
  endproperty
  property p_route4;
    ok_r && soc2_r[3] && soc2_r[0] && soc2_r[2] |-> PIN_OUT[7] == (soc2_r[7] ? PIN_OUT[4] : PIN_OUT[5]);
  endproperty
  property p_capt;
    s_capt |=> IRQ_OUT[4];
  endproperty
  property p_ec_masked;
    s_ec_off |-> !IRQ_OUT[5];
  endproperty
  property p_sync_off;
    ok_r && $past(cnf0_r[4:3] == MODE_CENTRED && soc0_r[5]) |-> !SYNC_OUT[0];
  endproperty
  a_oe0: assert property (p_oe0) else $error("output 0 enable wrong");
  a_oe1: assert property (p_oe1) else $error("output 1 enable wrong");
  a_oe6: assert property (p_oe6) else $error("third pin enable wrong");
  a_oe7: assert property (p_oe7) else $error("fourth pin enable wrong");
  a_route3: assert property (p_route3) else $error("third pin routing wrong");
  a_route4: assert property (p_route4) else $error("fourth pin routing wrong");
  a_capt: assert property (p_capt) else $error("capture request missing");
  a_ec_masked: assert property (p_ec_masked) else $error("masked end of cycle request");
  a_sync_off: assert property (p_sync_off) else $error("centred sync on idle code");
endmodule : pwc_cfg_props
bind pwc_cfg pwc_cfg_props u_props (.REF_CLK_IN, .ARST_N_IN, .CE_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
  .CAPT_EVT_IN, .PORT_OE_IN, .PIN_OUT, .PIN_OE_OUT, .IRQ_OUT, .SYNC_OUT);

// file: verif/pwc_cfg_tb.sv
`timescale 1ns/1ps
// self-checking bench: registers, clocking, requests, sync and pin routing
module pwc_cfg_tb
  import pwc_pkg::*;
;
  logic clk, rst_n, wr, rd, pll, ce;
  logic [7:0] addr, wdata, rdata, pd, poe, pin, oe, pad, h, l, s0, s2, en;
  logic [2:0] rta, rtb, capt, sync;
  logic [5:0] irq;
  logic [2:0][15:0] hits;
  logic [15:0] h0;
  int err_count, comparisons, cyc, n, r;
  pwc_cfg dut (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PLL_TICK_IN(pll), .RETRIG_A_IN(rta), .RETRIG_B_IN(rtb),
    .CAPT_EVT_IN(capt), .PORT_DATA_IN(pd), .PORT_OE_IN(poe), .PIN_OUT(pin), .PIN_OE_OUT(oe),
    .IRQ_OUT(irq), .SYNC_OUT(sync));
  pwc_stage u_stage (.clk_in(clk), .pin_in(pin), .oe_in(oe), .sync_in(sync), .pad_out(pad), .hits_out(hits));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pll ticks every other cycle; hang guard
  always @(posedge clk) begin
    pll <= ~pll;
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [15:0] div_of(input int p);
    return 16'h0001 << (p == 0 ? 0 : p == 1 ? 2 : p == 2 ? 5 : 8);
  endfunction : div_of
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, e});
  endtask : rdchk
  // cycles until the next request pulse on bit b
  task automatic wait_irq(input int b);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (irq[b] !== 1'b1 && n < 8000);
  endtask : wait_irq
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial begin
    {rst_n, wr, rd, pll, rta, rtb, capt} = '0;
    ce = 1'b1;
    {addr, wdata, pd, poe} = '0;
    {err_count, comparisons, cyc} = '0;
    void'($urandom(32'hd71a3d87));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, and an unmapped unit that ignores writes
    for (int u = 0; u < 3; u++) for (int o = 0; o < 16; o++) if (o < 4 || o > 7) rdchk(8'(u * 16 + o), 8'h00);
    wr8(8'h30, 8'ha5);
    rdchk(8'h30, 8'h00);
    $display("test reset done");
    // high byte held in the one shared buffer, committed by a low write elsewhere
    h = 8'($urandom);
    l = 8'($urandom);
    wr8(8'h09, h);
    wr8(8'h1e, l);
    rdchk(8'h1f, h);
    rdchk(8'h1e, l);
    rdchk(8'h09, 8'h00);
    wr8(8'h01, 8'h02);
    rdchk(8'h01, 8'h02);
    $display("test holding done");
    // end-of-cycle period for every source and prescaler code; top never shrinks
    r = $urandom_range(1, 6);
    wr8(8'h03, 8'h01);
    wr8(8'h0f, 8'h00);
    wr8(8'h0e, 8'(r));
    for (int s = 0; s < 2; s++) for (int p = 0; p < 4; p++) begin
      wr8(8'h02, 8'(p << 6));
      wr8(8'h01, 8'(s << 1));
      wait_irq(5);
      wait_irq(5);
      wait_irq(5);
      chk("ec period", n[15:0], 16'(div_of(p) * (r + 1) * (s + 1)));
    end
    $display("test period done");
    // every capture source of every unit lands on that unit's one vector bit
    wr8(8'h03, 8'h00);
    for (int u = 0; u < 3; u++) begin
      wr8(8'(u * 16 + 3), 8'h02);
      for (int e = 0; e < 3; e++) begin
        @(posedge clk);
        {rta, rtb, capt} <= 9'(3'(1 << u)) << (3 * e);
        @(posedge clk);
        {rta, rtb, capt} <= '0;
        #1 chk("capt vector", {10'h000, irq & 6'h15}, 16'h0001 << (2 * (2 - u)));
      end
      wr8(8'(u * 16 + 3), 8'h00);
    end
    $display("test capture done");
    // sync codes in ramp then centred mode; RA kept at 8, not below one
    wr8(8'h0f, 8'h00);
    wr8(8'h0e, 8'h0f);
    wr8(8'h08, 8'h03);
    wr8(8'h0a, 8'h08);
    wr8(8'h0c, 8'h05);
    wr8(8'h02, 8'h00);
    for (int m = 0; m < 2; m++) for (int c = 0; c < 4; c++) begin
      wr8(8'h01, m ? 8'h18 : 8'h00);
      wr8(8'h00, 8'(c << 4));
      repeat (4) @(posedge clk);
      #1 h0 = hits[0];
      repeat (64) @(posedge clk);
      #1 if (m == 0) chk("ramp sync", hits[0] - h0, 16'h0004);
      else chk("centred sync", 16'(hits[0] != h0), 16'(c < 2));
    end
    $display("test sync done");
    // random routing and enables against ordinary port values
    wr8(8'h2f, 8'h00);
    wr8(8'h2e, 8'h07);
    wr8(8'h2c, 8'h03);
    wr8(8'h28, 8'h01);
    wr8(8'h2a, 8'h04);
    for (int i = 0; i < 16; i++) begin
      s0 = 8'($urandom);
      s2 = 8'($urandom) | 8'h05;
      wr8(8'h00, s0);
      wr8(8'h20, s2);
      pd <= 8'($urandom);
      poe <= 8'($urandom);
      repeat (2) @(posedge clk);
      en = {s2[3], s2[1], s2[2], s2[0], 2'b00, s0[2], s0[0]};
      #1 chk("pin oe", {8'h00, oe}, {8'h00, en | poe});
      chk("port pins", {8'h00, pin & ~en}, {8'h00, pd & ~en});
    end
    $display("test pins done");
    // enable low freezes every output although the port side moves
    @(posedge clk);
    ce <= 1'b0;
    pd <= ~pd;
    poe <= ~poe;
    repeat (3) @(posedge clk);
    #1 chk("frozen oe", {8'h00, oe}, {8'h00, en | ~poe});
    chk("frozen pins", {8'h00, pin & ~en}, {8'h00, ~pd & ~en});
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("released oe", {8'h00, oe}, {8'h00, en | poe});
    $display("test freeze done");
    finish_test();
  end
endmodule : pwc_cfg_tb
